// ===== core/satt_map.svh
// constants of the step attenuator control port and its controller
`ifndef SATT_MAP_SVH
`define SATT_MAP_SVH

// code and word widths
`define SATT_CODE_W       6
`define SATT_WORD_W       8
`define SATT_DB10_W       9
`define SATT_CNT_W        4
`define SATT_RST_CODE     6'h3F
`define SATT_RST_DB10     9'h13B

// bit weights in tenths of a dB: 0.5, 1.0, 2.0, 4.0, 8.0, 16.0 dB
`define SATT_W_B0         9'h005
`define SATT_W_B1         9'h00A
`define SATT_W_B2         9'h014
`define SATT_W_B3         9'h028
`define SATT_W_B4         9'h050
`define SATT_W_B5         9'h0A0

// synchroniser lanes on the device side
`define SATT_SYNC_W       10
`define SATT_IX_PAR       0
`define SATT_IX_SIN       6
`define SATT_IX_SCLK      7
`define SATT_IX_LE        8
`define SATT_IX_PS        9

// serial clock made by the controller: half period rounded up to whole cycles
`define SATT_SYS_PERIOD_NS  40
`define SATT_SCLK_PERIOD_NS 320
`define SATT_HALF_CNT     ((`SATT_SCLK_PERIOD_NS / 2 + `SATT_SYS_PERIOD_NS - 1) / `SATT_SYS_PERIOD_NS)

// controller register map (byte addresses)
`define SATT_ADDR_W       12
`define SATT_OFS_CTRL     12'h000
`define SATT_OFS_DATA     12'h004
`define SATT_OFS_STATUS   12'h008
`define SATT_CTRL_SERIAL  0
`define SATT_CTRL_LATCH   1
`define SATT_CTRL_WORD8   2
`define SATT_STAT_BUSY    0
`define SATT_STAT_SERIAL_OUT  1

`endif

// ===== core/satt_pkg.sv
// types shared by both ends of the attenuator control link
`include "satt_map.svh"
package satt_pkg;

	// controller sequencer, one-hot
	typedef enum logic [3:0] {
		SATT_IDLE   = 4'h1,
		SATT_LOW    = 4'h2,
		SATT_HIGH   = 4'h4,
		SATT_STROBE = 4'h8
	} satt_seq_type;

	// device control mode, one-hot
	typedef enum logic [2:0] {
		SATT_MODE_SERIAL  = 3'h1,
		SATT_MODE_DIRECT  = 3'h2,
		SATT_MODE_LATCHED = 3'h4
	} satt_mode_type;

	typedef struct packed {
		logic [`SATT_SYNC_W-1:0] meta;
		logic [`SATT_SYNC_W-1:0] sync;
	} satt_sync_st_type;

	typedef struct packed {
		logic                    sclk_q;
		logic                    le_q;
		logic [`SATT_WORD_W-1:0] shreg;
		logic [`SATT_CNT_W-1:0]  shift_cnt;
		logic [`SATT_CODE_W-1:0] state;
		logic [`SATT_DB10_W-1:0] db10;
		satt_mode_type           mode;
	} satt_dev_st_type;

	typedef struct packed {
		satt_seq_type            seq;
		logic                    ctrl_serial;
		logic                    ctrl_latch;
		logic                    ctrl_word8;
		logic [`SATT_WORD_W-1:0] data;
		logic [`SATT_WORD_W-1:0] sh;
		logic [`SATT_CNT_W-1:0]  bits;
		logic [`SATT_CNT_W-1:0]  tmr;
		logic                    ps;
		logic                    le;
		logic                    sclk;
		logic                    sin;
		logic [`SATT_CODE_W-1:0] par;
		logic                    serial_out_m;
		logic                    serial_out_s;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} satt_ctl_st_type;

endpackage

// ===== core/satt_link_if.sv
// control pins between the external controller and the attenuator
interface satt_link_if;
	logic interface_select;
	logic latch_strobe;
	logic serial_in;
	logic serial_clk;
	logic serial_out;
	logic atten_bit_half_db;
	logic atten_bit_1db;
	logic atten_bit_2db;
	logic atten_bit_4db;
	logic atten_bit_8db;
	logic atten_bit_16db;

	modport dev (
		input  interface_select, latch_strobe, serial_in, serial_clk,
		input  atten_bit_half_db, atten_bit_1db, atten_bit_2db,
		input  atten_bit_4db, atten_bit_8db, atten_bit_16db,
		output serial_out
	);

	modport ctl (
		output interface_select, latch_strobe, serial_in, serial_clk,
		output atten_bit_half_db, atten_bit_1db, atten_bit_2db,
		output atten_bit_4db, atten_bit_8db, atten_bit_16db,
		input  serial_out
	);
endinterface

// ===== core/satt_sync.sv
// two-flop synchroniser for the device's pin inputs
`include "satt_map.svh"
module satt_sync (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire logic [`SATT_SYNC_W-1:0] pins,
	output      logic [`SATT_SYNC_W-1:0] synced
);
	satt_pkg::satt_sync_st_type s_r;
	satt_pkg::satt_sync_st_type s_nxt;

	// first stage feeds only the second stage
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = pins;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign synced = s_r.sync;
endmodule

// ===== core/satt_dev.sv
// attenuator end: serial and parallel control logic of the 6-bit step attenuator
//
// Operation
// RULE1: attenuation is sum of set bit weights
// RULE2: select high means serial, low parallel
// RULE3: accept 6 or 8 bit words, low six
// RULE4: msb first, one shift per rising clock
// RULE5: strobe high moves shifted code to state
// RULE6: clock ignored while strobe high
// RULE7: serial output is input delayed eight clocks
// RULE8: chained devices need full 8-bit words
// RULE9: serial output always driven, never released
// RULE10: parallel code from six inputs, bit0 lsb
// RULE11: strobe held high: state follows inputs
// RULE12: strobe pulse latches parallel code, then holds
// RULE13: reset gives maximum attenuation 31.5 dB
// RULE14: serial state captured on strobe rising edge
`include "satt_map.svh"
module satt_dev (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	satt_link_if.dev                     link,
	output      logic [`SATT_CODE_W-1:0] atten_state,
	output      logic [`SATT_DB10_W-1:0] atten_db10,
	output      logic [2:0]              atten_mode,
	output      logic [`SATT_CNT_W-1:0]  shift_count
);
	satt_pkg::satt_dev_st_type s_r;
	satt_pkg::satt_dev_st_type s_nxt;

	logic [`SATT_SYNC_W-1:0] pins;
	logic [`SATT_SYNC_W-1:0] synced;
	logic [`SATT_CODE_W-1:0] par_code;
	logic                    ps_s;
	logic                    le_s;
	logic                    sclk_s;
	logic                    sin_s;
	logic                    sclk_rise;
	logic                    le_rise;

	// sum of the weights of the set code bits, in tenths of a dB
	function automatic logic [`SATT_DB10_W-1:0] satt_db10(
		input logic [`SATT_CODE_W-1:0] code
	);
		logic [`SATT_DB10_W-1:0] sum;
		sum = '0;
		if (code[0]) begin
			sum = sum + `SATT_W_B0;
		end
		if (code[1]) begin
			sum = sum + `SATT_W_B1;
		end
		if (code[2]) begin
			sum = sum + `SATT_W_B2;
		end
		if (code[3]) begin
			sum = sum + `SATT_W_B3;
		end
		if (code[4]) begin
			sum = sum + `SATT_W_B4;
		end
		if (code[5]) begin
			sum = sum + `SATT_W_B5;
		end
		return sum;
	endfunction

	// mode seen from the select and strobe levels
	function automatic satt_pkg::satt_mode_type satt_mode_of(
		input logic ps,
		input logic le
	);
		satt_pkg::satt_mode_type m;
		if (ps) begin
			m = satt_pkg::SATT_MODE_SERIAL;
		end else if (le) begin
			m = satt_pkg::SATT_MODE_DIRECT;
		end else begin
			m = satt_pkg::SATT_MODE_LATCHED;
		end
		return m;
	endfunction

	// every pin comes from the controller's domain, so all pass the synchroniser
	assign pins = {link.interface_select,
	               link.latch_strobe,
	               link.serial_clk,
	               link.serial_in,
	               link.atten_bit_16db,
	               link.atten_bit_8db,
	               link.atten_bit_4db,
	               link.atten_bit_2db,
	               link.atten_bit_1db,
	               link.atten_bit_half_db};

	satt_sync i_satt_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pins    (pins),
		.synced  (synced)
	);

	// named views of the synchronised lanes
	assign par_code = synced[`SATT_IX_PAR +: `SATT_CODE_W]; // RULE10
	assign ps_s     = synced[`SATT_IX_PS];
	assign le_s     = synced[`SATT_IX_LE];
	assign sclk_s   = synced[`SATT_IX_SCLK];
	assign sin_s    = synced[`SATT_IX_SIN];

	// edges are found on synchronised copies only, never on the first stage
	assign sclk_rise = sclk_s & ~s_r.sclk_q;
	assign le_rise   = le_s & ~s_r.le_q;

	// next state of the whole control port
	always_comb begin
		s_nxt        = s_r;
		s_nxt.sclk_q = sclk_s;
		s_nxt.le_q   = le_s;
		if (ps_s) begin // RULE2
			// clock is masked while the strobe is high, so no shift can slip in
			if (sclk_rise && !le_s) begin // RULE6
				// msb arrives first and moves up one place per edge
				s_nxt.shreg = {s_r.shreg[`SATT_WORD_W-2:0], sin_s}; // RULE4
				if (s_r.shift_cnt != 4'hF) begin
					s_nxt.shift_cnt = s_r.shift_cnt + 4'h1;
				end
			end
			// only the low six bits count; leading pad bits stay in the top two places
			if (le_rise) begin // RULE5
				s_nxt.state     = s_r.shreg[`SATT_CODE_W-1:0]; // RULE3 RULE14
				s_nxt.shift_cnt = '0;
			end
		end else begin
			// strobe high follows the inputs, strobe low holds the last value
			if (le_s) begin // RULE11 RULE12
				s_nxt.state = par_code; // RULE10
			end
		end
		s_nxt.mode = satt_mode_of(ps_s, le_s);
		s_nxt.db10 = satt_db10(s_nxt.state); // RULE1
	end

	// reset lands on the full 31.5 dB state before any strobe is seen
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_r.sclk_q    <= 1'b0;
			s_r.le_q      <= 1'b0;
			s_r.shreg     <= '0;
			s_r.shift_cnt <= '0;
			s_r.state     <= `SATT_RST_CODE; // RULE13
			s_r.db10      <= `SATT_RST_DB10; // RULE13
			s_r.mode      <= satt_pkg::SATT_MODE_LATCHED;
		end else begin
			s_r <= s_nxt;
		end
	end

	// top bit of the 8-deep shift path is the cascade output, driven at all times
	assign link.serial_out = s_r.shreg[`SATT_WORD_W-1]; // RULE7 RULE9

	// outputs straight from the state flops
	assign atten_state = s_r.state;
	assign atten_db10  = s_r.db10;
	assign atten_mode  = s_r.mode;
	assign shift_count = s_r.shift_cnt;
endmodule

// ===== core/satt_ctl.sv
// controller end: drives the attenuator pins on orders taken over APB
`include "satt_map.svh"
module satt_ctl (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`SATT_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output      logic [31:0]             prdata,
	output      logic                    pready,
	output      logic                    pslverr,
	satt_link_if.ctl                     link
);
	satt_pkg::satt_ctl_st_type s_r;
	satt_pkg::satt_ctl_st_type s_nxt;

	logic                   busy;
	logic                   acc;
	logic [`SATT_CNT_W-1:0] half;

	// register index: 0 ctrl, 1 data, 2 status, 3 unmapped
	function automatic logic [1:0] satt_dec(input logic [`SATT_ADDR_W-1:0] a);
		logic [1:0] ix;
		if (a == `SATT_OFS_CTRL) begin
			ix = 2'h0;
		end else if (a == `SATT_OFS_DATA) begin
			ix = 2'h1;
		end else if (a == `SATT_OFS_STATUS) begin
			ix = 2'h2;
		end else begin
			ix = 2'h3;
		end
		return ix;
	endfunction

	assign busy = (s_r.seq != satt_pkg::SATT_IDLE);
	assign acc  = psel & penable;
	assign half = `SATT_CNT_W'(`SATT_HALF_CNT);

	always_comb begin
		s_nxt          = s_r;
		s_nxt.pready   = 1'b0;
		s_nxt.pslverr  = 1'b0;
		// cascade output passes two flops before status reads it
		s_nxt.serial_out_m = link.serial_out;
		s_nxt.serial_out_s = s_r.serial_out_m;
		// first access cycle: prepare the answer, raise ready a cycle later
		if (acc && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
			case (satt_dec(paddr))
				2'h0: begin
					s_nxt.prdata[`SATT_CTRL_SERIAL] = s_r.ctrl_serial;
					s_nxt.prdata[`SATT_CTRL_LATCH]  = s_r.ctrl_latch;
					s_nxt.prdata[`SATT_CTRL_WORD8]  = s_r.ctrl_word8;
				end
				2'h1: s_nxt.prdata[`SATT_WORD_W-1:0] = s_r.data;
				2'h2: begin
					s_nxt.prdata[`SATT_STAT_BUSY]   = busy;
					s_nxt.prdata[`SATT_STAT_SERIAL_OUT] = s_r.serial_out_s;
				end
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		// writes land at the edge where ready is sampled; ignored while busy
		if (acc && s_r.pready && pwrite && !busy) begin
			if (satt_dec(paddr) == 2'h0) begin
				s_nxt.ctrl_serial = pwdata[`SATT_CTRL_SERIAL];
				s_nxt.ctrl_latch  = pwdata[`SATT_CTRL_LATCH];
				s_nxt.ctrl_word8  = pwdata[`SATT_CTRL_WORD8];
			end else if (satt_dec(paddr) == 2'h1) begin
				s_nxt.data = pwdata[`SATT_WORD_W-1:0];
				if (s_r.ctrl_serial) begin
					// six-bit words are left aligned so the code msb goes first
					s_nxt.sh   = s_r.ctrl_word8 ? pwdata[`SATT_WORD_W-1:0]
					                            : {pwdata[`SATT_CODE_W-1:0], 2'b00};
					s_nxt.bits = s_r.ctrl_word8 ? 4'h8 : 4'h6; // RULE3 RULE8
					s_nxt.seq  = satt_pkg::SATT_LOW;
				end else begin
					s_nxt.par  = pwdata[`SATT_CODE_W-1:0]; // RULE10
					s_nxt.bits = '0;
					s_nxt.seq  = s_r.ctrl_latch ? satt_pkg::SATT_LOW : satt_pkg::SATT_IDLE;
				end
				s_nxt.tmr = half;
			end
		end
		// pin sequencer: each phase lasts half a serial clock period
		case (s_r.seq)
			satt_pkg::SATT_IDLE: begin
				s_nxt.ps   = s_r.ctrl_serial; // RULE2
				// direct parallel keeps the strobe high, others keep it low
				s_nxt.le   = !s_r.ctrl_serial && !s_r.ctrl_latch; // RULE11
				s_nxt.sclk = 1'b0;
			end
			satt_pkg::SATT_LOW: begin
				s_nxt.le   = 1'b0; // RULE6 RULE12
				s_nxt.sclk = 1'b0;
				s_nxt.sin  = s_r.sh[`SATT_WORD_W-1]; // RULE4
				s_nxt.tmr  = s_r.tmr - 4'h1;
				if (s_r.tmr == 4'h1) begin
					s_nxt.tmr = half;
					s_nxt.seq = (s_r.bits == '0) ? satt_pkg::SATT_STROBE : satt_pkg::SATT_HIGH;
				end
			end
			satt_pkg::SATT_HIGH: begin
				s_nxt.sclk = 1'b1;
				s_nxt.tmr  = s_r.tmr - 4'h1;
				if (s_r.tmr == 4'h1) begin
					s_nxt.tmr  = half;
					s_nxt.sh   = {s_r.sh[`SATT_WORD_W-2:0], 1'b0};
					s_nxt.bits = s_r.bits - 4'h1;
					s_nxt.seq  = satt_pkg::SATT_LOW;
				end
			end
			satt_pkg::SATT_STROBE: begin
				s_nxt.le  = 1'b1; // RULE5 RULE12
				s_nxt.tmr = s_r.tmr - 4'h1;
				if (s_r.tmr == 4'h1) begin
					s_nxt.seq = satt_pkg::SATT_IDLE;
				end
			end
			default: s_nxt.seq = satt_pkg::SATT_IDLE;
		endcase
	end

	// parallel code starts at all ones so the attenuator powers up at full attenuation
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_r     <= '0;
			s_r.seq <= satt_pkg::SATT_IDLE;
			s_r.par <= `SATT_RST_CODE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata                 = s_r.prdata;
	assign pready                 = s_r.pready;
	assign pslverr                = s_r.pslverr;
	assign link.interface_select  = s_r.ps;
	assign link.latch_strobe      = s_r.le;
	assign link.serial_clk        = s_r.sclk;
	assign link.serial_in         = s_r.sin;
	assign link.atten_bit_half_db = s_r.par[0];
	assign link.atten_bit_1db     = s_r.par[1];
	assign link.atten_bit_2db     = s_r.par[2];
	assign link.atten_bit_4db     = s_r.par[3];
	assign link.atten_bit_8db     = s_r.par[4];
	assign link.atten_bit_16db    = s_r.par[5];
endmodule

// ===== test/satt_link_chk.sv
// concurrent checks on the attenuator control pins and device outputs
`include "satt_map.svh"
module satt_link_chk (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       interface_select,
	input wire logic       latch_strobe,
	input wire logic       serial_in,
	input wire logic       serial_clk,
	input wire logic       serial_out,
	input wire logic       atten_bit_half_db,
	input wire logic       atten_bit_1db,
	input wire logic       atten_bit_2db,
	input wire logic       atten_bit_4db,
	input wire logic       atten_bit_8db,
	input wire logic       atten_bit_16db,
	input wire logic [5:0] atten_state,
	input wire logic [8:0] atten_db10,
	input wire logic [2:0] atten_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] par_code;
	logic [7:0] hist_r;
	logic       sclk_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// weight sum in tenths of a dB, kept apart from the device adder
	function automatic logic [8:0] db_of(input logic [5:0] c);
		db_of = 9'h000;
		for (int b = 0; b < 6; b++) begin
			if (c[b]) begin
				db_of = db_of + (9'h005 << b);
			end
		end
	endfunction

	// parallel pins, bit 0 the lsb
	assign par_code = {atten_bit_16db, atten_bit_8db, atten_bit_4db,
		atten_bit_2db, atten_bit_1db, atten_bit_half_db};

	// bits the device should hold; rises under a high strobe are masked
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sclk_r <= 1'b0;
			hist_r <= 8'h00;
		end else begin
			sclk_r <= serial_clk;
			if (serial_clk && !sclk_r && interface_select && !latch_strobe) begin
				hist_r <= {hist_r[6:0], serial_in};
			end
		end
	end

	chk_db_weight: assert property (atten_db10 == db_of(atten_state))
		else $error("level differs from code weights");
	chk_mode_serial: assert property (interface_select [*4] |-> atten_mode == 3'h1)
		else $error("serial select not honoured");
	chk_mode_par: assert property (!interface_select [*4] |-> atten_mode != 3'h1)
		else $error("parallel select not honoured");
	chk_sclk_phase: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
		else $error("serial clock high phase length");
	chk_sin_steady: assert property (serial_clk |-> $stable(serial_in))
		else $error("serial data moved while clock high");
	chk_strobe_len: assert property ($rose(latch_strobe) && interface_select
		|-> latch_strobe [*4] ##1 !latch_strobe)
		else $error("serial strobe length");
	chk_strobe_no_clk: assert property (latch_strobe |-> !serial_clk)
		else $error("clock pulsed under strobe");
	chk_serial_load: assert property ($rose(latch_strobe) && interface_select
		|-> ##[1:4] atten_state == hist_r[5:0])
		else $error("strobe did not load shifted code");
	chk_cascade_out: assert property ($fell(serial_clk) && interface_select
		|-> serial_out == hist_r[7])
		else $error("cascade output not eight bits late");
	chk_direct_follow: assert property ((!interface_select && latch_strobe
		&& $stable(par_code)) [*4] |-> atten_state == par_code)
		else $error("direct mode not following inputs");
	chk_latched_hold: assert property ((!interface_select && !latch_strobe) [*4]
		|-> $stable(atten_state))
		else $error("latched state moved without strobe");
endmodule

// ===== test/tb_step_attenuator_control_port.sv
// self-checking bench: controller and attenuator joined over their control pins
`include "satt_map.svh"
`define CHK(a, b, m) \
	begin \
		n_tests++; \
		if ((a) !== (b)) begin \
			err_count++; \
			$display("CHECK FAILED %0t %s", $time, m); \
		end \
	end
module tb_step_attenuator_control_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  atten_state;
	logic [8:0]  atten_db10;
	logic [2:0]  atten_mode;
	logic [3:0]  shift_count;
	logic [31:0] rd_data;
	logic        rd_err;
	int          err_count;
	int          n_tests;

	satt_link_if link ();
	satt_ctl i_satt_ctl (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	satt_dev i_satt_dev (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
		.atten_state(atten_state), .atten_db10(atten_db10),
		.atten_mode(atten_mode), .shift_count(shift_count));
	satt_link_chk i_satt_link_chk (.clk_sys(clk_sys), .rst_b(rst_b),
		.interface_select(link.interface_select), .latch_strobe(link.latch_strobe),
		.serial_in(link.serial_in), .serial_clk(link.serial_clk),
		.serial_out(link.serial_out), .atten_bit_half_db(link.atten_bit_half_db),
		.atten_bit_1db(link.atten_bit_1db), .atten_bit_2db(link.atten_bit_2db),
		.atten_bit_4db(link.atten_bit_4db), .atten_bit_8db(link.atten_bit_8db),
		.atten_bit_16db(link.atten_bit_16db), .atten_state(atten_state),
		.atten_db10(atten_db10), .atten_mode(atten_mode));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// a stuck wait counts as a mismatch and ends the run
	task automatic give_up(input string m);
		err_count++;
		$display("CHECK FAILED %0t %s", $time, m);
		finish_test();
	endtask

	// one apb transfer; the request stands until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) begin
				break;
			end
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			give_up("apb timeout");
		end
	endtask

	// poll status until the controller is idle
	task automatic wait_idle();
		int k;
		for (k = 0; k < 100; k++) begin
			apb(1'b0, `SATT_OFS_STATUS, 32'h0);
			if (rd_data[`SATT_STAT_BUSY] === 1'b0) begin
				break;
			end
		end
		if (k == 100) begin
			give_up("busy stuck");
		end
	endtask

	task automatic t_reset();
		`CHK(atten_state, 6'h3F, "reset code")
		`CHK(atten_db10, 9'h13B, "reset level")
		`CHK(shift_count, 4'h0, "reset shift count")
		$display("test reset done");
	endtask

	// each bit alone, all ones and all zeros, inputs followed directly
	task automatic t_direct();
		logic [5:0] codes [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F, 6'h00};
		logic [8:0] e;
		apb(1'b1, `SATT_OFS_CTRL, 32'h0);
		foreach (codes[i]) begin
			apb(1'b1, `SATT_OFS_DATA, {26'h0, codes[i]});
			repeat (8) @(posedge clk_sys);
			e = 9'h000;
			for (int b = 0; b < 6; b++) begin
				if (codes[i][b]) begin
					e = e + (9'h005 << b);
				end
			end
			`CHK(atten_state, codes[i], "direct code")
			`CHK(atten_db10, e, "direct level")
			`CHK(atten_mode, 3'h2, "direct mode")
		end
		$display("test direct done");
	endtask

	// new inputs must not show before the strobe pulse
	task automatic t_latched();
		logic [5:0] w [2] = '{6'h15, 6'h2A};
		logic [5:0] prev;
		prev = 6'h00;
		apb(1'b1, `SATT_OFS_CTRL, 32'h2);
		foreach (w[i]) begin
			apb(1'b1, `SATT_OFS_DATA, {26'h0, w[i]});
			repeat (2) @(posedge clk_sys);
			`CHK(atten_state, prev, "latched early")
			wait_idle();
			repeat (4) @(posedge clk_sys);
			`CHK(atten_state, w[i], "latched code")
			`CHK(atten_mode, 3'h4, "latched mode")
			prev = w[i];
		end
		$display("test latched done");
	endtask

	// one 6-bit word, then 8-bit words whose pad bits differ
	task automatic t_serial();
		logic [7:0] w [4] = '{8'h2A, 8'hC5, 8'h45, 8'h3F};
		logic [31:0] cfg [4] = '{32'h1, 32'h5, 32'h5, 32'h5};
		logic [5:0] prev;
		prev = 6'h2A;
		foreach (w[i]) begin
			apb(1'b1, `SATT_OFS_CTRL, cfg[i]);
			apb(1'b1, `SATT_OFS_DATA, {24'h0, w[i]});
			repeat (8) @(posedge clk_sys);
			`CHK(atten_state, prev, "serial early")
			wait_idle();
			repeat (6) @(posedge clk_sys);
			`CHK(atten_state, w[i][5:0], "serial code")
			`CHK(shift_count, 4'h0, "count cleared by strobe")
			`CHK(atten_mode, 3'h1, "serial mode")
			`CHK(link.serial_out, w[i][7], "cascade pin")
			apb(1'b0, `SATT_OFS_STATUS, 32'h0);
			`CHK(rd_data[`SATT_STAT_SERIAL_OUT], w[i][7], "cascade status")
			prev = w[i][5:0];
		end
		$display("test serial done");
	endtask

	// unmapped place and read-only status
	task automatic t_regs();
		apb(1'b0, `SATT_OFS_CTRL, 32'h0);
		`CHK(rd_data, 32'h5, "ctrl readback")
		apb(1'b0, `SATT_OFS_DATA, 32'h0);
		`CHK(rd_data, 32'h3F, "data readback")
		apb(1'b0, 12'h00C, 32'h0);
		`CHK(rd_err, 1'b1, "unmapped read flag")
		`CHK(rd_data, 32'h0, "unmapped read data")
		apb(1'b1, 12'h00C, 32'h3);
		`CHK(rd_err, 1'b1, "unmapped write flag")
		apb(1'b1, `SATT_OFS_STATUS, 32'h1);
		apb(1'b0, `SATT_OFS_STATUS, 32'h0);
		`CHK(rd_data[`SATT_STAT_BUSY], 1'b0, "status read only")
		$display("test regs done");
	endtask

	// reset in mid-run returns to maximum attenuation
	task automatic t_reset_again();
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk_sys);
		`CHK(atten_state, 6'h3F, "second reset")
		$display("test second reset done");
	endtask

	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_direct();
		t_latched();
		t_serial();
		t_regs();
		t_reset_again();
		finish_test();
	end
endmodule
